//--- design/dsa_params.svh
`ifndef DSA_PARAMS_SVH
`define DSA_PARAMS_SVH

// Data space map, byte addresses
`define DSA_WREG_END      16'h001F
`define DSA_REG_AREA_END  16'h07FF
`define DSA_RAM_BASE      16'h0800
`define DSA_RAM_END       16'h1FFF
`define DSA_NEAR_MASK     16'h1FFF

// Word storage behind the register region
`define DSA_RAM_WORDS     3072
`define DSA_RAM_BASE_WORD 12'h400

// Dual-ported tail of the data RAM (2 Kbyte variant)
`define DSA_DMA_BASE_IDX  12'h800

// Post-increment steps
`define DSA_STEP_BYTE     16'h0001
`define DSA_STEP_WORD     16'h0002

`endif

//--- design/dsa_pkg.sv
`default_nettype none

package dsa_pkg;

  // Effective address forms
  typedef enum logic [1:0] {
    AM_DIRECT      = 2'b00,
    AM_NEAR        = 2'b01,
    AM_IND         = 2'b10,
    AM_IND_POSTINC = 2'b11
  } addr_mode_t;

  // Working register operations
  typedef enum logic [1:0] {
    OP_NONE        = 2'b00,
    OP_SIGN_EXTEND = 2'b01,
    OP_CLEAR_UPPER = 2'b10
  } reg_op_t;

  // Data read request from the core
  typedef struct packed {
    logic        en;
    logic        byte_op;
    addr_mode_t  mode;
    logic [3:0]  ptr;
    logic [15:0] lit;
    logic        load;
    logic [3:0]  dest;
  } rd_req_t;

  // Data write request from the core
  typedef struct packed {
    logic        en;
    logic        byte_op;
    addr_mode_t  mode;
    logic [3:0]  ptr;
    logic [15:0] lit;
    logic [15:0] data;
  } wr_req_t;

  // Working register operation request
  typedef struct packed {
    reg_op_t    op;
    logic [3:0] sel;
  } reg_op_req_t;

  // DMA controller port into the dual-ported area
  typedef struct packed {
    logic        en;
    logic        we;
    logic [9:0]  addr;
    logic [1:0]  be;
    logic [15:0] data;
  } dma_req_t;

  // Read answer to the core
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } rd_resp_t;

endpackage

`default_nettype wire

//--- design/data_space_access_unit.sv
`include "dsa_params.svh"
`default_nettype none

module data_space_access_unit (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire dsa_pkg::rd_req_t     rd_req,
  input  wire dsa_pkg::wr_req_t     wr_req,
  input  wire dsa_pkg::reg_op_req_t reg_op,
  input  wire dsa_pkg::dma_req_t    dma_req,
  output var  dsa_pkg::rd_resp_t    rd_resp_q,
  output var  logic                 addr_trap_q,
  output var  logic [15:0]          dma_rdata_q
);

  // Working registers, mapped at the bottom of the register region
  logic [15:0] wreg_q [0:15];
  // Data RAM words; plain storage, so no reset
  logic [15:0] ram_q [0:`DSA_RAM_WORDS-1];

  logic [15:0] rd_effective_address; // Read address from its own unit
  logic [15:0] wr_effective_address; // Write address from its own unit
  logic        rd_mis;       // Odd word read
  logic        wr_mis;       // Odd word write
  logic [11:0] rd_idx;       // RAM word index for reads
  logic [11:0] wr_idx;       // RAM word index for writes
  logic [11:0] dma_idx;      // RAM word index for DMA
  logic [15:0] rd_word;      // Whole word fetched
  logic [15:0] rd_sel;       // Word or selected byte
  logic        wr_in_wreg;   // Store hits a working register
  logic        wr_in_ram;    // Store hits the data RAM
  logic [1:0]  wr_lane;      // Byte lanes the store may touch
  logic [15:0] wr_lane_data; // Store data placed on both lanes
  logic [1:0]  dma_lane;     // Byte lanes the DMA writes
  logic [15:0] rd_step;      // Read pointer increment
  logic [15:0] wr_step;      // Write pointer increment

  // Address generation: one unit per direction
  // Near form keeps only the 13-bit field, so it never leaves the near 8 Kbytes
  function automatic logic [15:0] address_generation_unit(input dsa_pkg::addr_mode_t m,
                                                          input logic [15:0]         ptr,
                                                          input logic [15:0]         lit);
    case (m)
      dsa_pkg::AM_DIRECT: address_generation_unit = lit;
      dsa_pkg::AM_NEAR:   address_generation_unit = lit & `DSA_NEAR_MASK;
      default:            address_generation_unit = ptr;
    endcase
  endfunction

  // Two independent address units
  assign rd_effective_address = address_generation_unit(rd_req.mode, wreg_q[rd_req.ptr], rd_req.lit);
  assign wr_effective_address = address_generation_unit(wr_req.mode, wreg_q[wr_req.ptr], wr_req.lit);

  // Odd address on a word access
  assign rd_mis = rd_req.en & ~rd_req.byte_op & rd_effective_address[0];
  assign wr_mis = wr_req.en & ~wr_req.byte_op & wr_effective_address[0];

  // Word index within RAM; bit 0 only picks the lane
  assign rd_idx  = rd_effective_address[12:1] - `DSA_RAM_BASE_WORD;
  assign wr_idx  = wr_effective_address[12:1] - `DSA_RAM_BASE_WORD;
  assign dma_idx = `DSA_DMA_BASE_IDX + {2'b00, dma_req.addr};

  // Pointer steps scale with operand size
  assign rd_step = rd_req.byte_op ? `DSA_STEP_BYTE : `DSA_STEP_WORD;
  assign wr_step = wr_req.byte_op ? `DSA_STEP_BYTE : `DSA_STEP_WORD;

  // Read decode: reserved half, register region, RAM, else zero
  always_comb begin
    rd_word = 16'h0000;
    if (!rd_effective_address[15]) begin
      if (rd_effective_address <= `DSA_WREG_END) begin
        rd_word = wreg_q[rd_effective_address[4:1]];
      end else if (rd_effective_address >= `DSA_RAM_BASE && rd_effective_address <= `DSA_RAM_END) begin
        rd_word = ram_q[rd_idx];
      end
    end
  end

  // Byte read takes the lane picked by address bit 0
  always_comb begin
    if (rd_req.byte_op) begin
      rd_sel = {8'h00, rd_effective_address[0] ? rd_word[15:8] : rd_word[7:0]};
    end else begin
      rd_sel = rd_word;
    end
  end

  // Store target decode; reserved and unused areas swallow stores
  assign wr_in_wreg = ~wr_effective_address[15] & (wr_effective_address <= `DSA_WREG_END);
  assign wr_in_ram  = ~wr_effective_address[15] & (wr_effective_address >= `DSA_RAM_BASE) &
                      (wr_effective_address <= `DSA_RAM_END);

  // Lane strobes; a misaligned store drives none of them
  always_comb begin
    if (!wr_req.en || wr_mis) begin
      wr_lane = 2'b00;
    end else if (wr_req.byte_op) begin
      wr_lane = wr_effective_address[0] ? 2'b10 : 2'b01;
    end else begin
      wr_lane = 2'b11;
    end
  end

  // Byte data mirrored so either lane can take it
  assign wr_lane_data = wr_req.byte_op ? {2{wr_req.data[7:0]}} : wr_req.data;

  // DMA lanes only on a write
  assign dma_lane = (dma_req.en && dma_req.we) ? dma_req.be : 2'b00;

  // RAM update: DMA first, CPU after, so the CPU lane wins a collision
  always_ff @(posedge core_clk) begin
    if (dma_lane[0]) begin
      ram_q[dma_idx][7:0] <= dma_req.data[7:0];
    end
    if (dma_lane[1]) begin
      ram_q[dma_idx][15:8] <= dma_req.data[15:8];
    end
    if (wr_in_ram && wr_lane[0]) begin
      ram_q[wr_idx][7:0] <= wr_lane_data[7:0];
    end
    if (wr_in_ram && wr_lane[1]) begin
      ram_q[wr_idx][15:8] <= wr_lane_data[15:8];
    end
  end

  // DMA read port; the CPU is never held off by it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dma_rdata_q <= 16'h0000;
    end else if (dma_req.en && !dma_req.we) begin
      dma_rdata_q <= ram_q[dma_idx];
    end
  end

  // Working registers; later writers in this block take priority
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        wreg_q[i] <= 16'h0000;
      end
    end else begin
      // Memory-mapped stores into the register file
      if (wr_in_wreg && wr_lane[0]) begin
        wreg_q[wr_effective_address[4:1]][7:0] <= wr_lane_data[7:0];
      end
      if (wr_in_wreg && wr_lane[1]) begin
        wreg_q[wr_effective_address[4:1]][15:8] <= wr_lane_data[15:8];
      end
      // Pointer post-increment, even when the access traps
      if (wr_req.en && wr_req.mode == dsa_pkg::AM_IND_POSTINC) begin
        wreg_q[wr_req.ptr] <= wreg_q[wr_req.ptr] + wr_step;
      end
      if (rd_req.en && rd_req.mode == dsa_pkg::AM_IND_POSTINC) begin
        wreg_q[rd_req.ptr] <= wreg_q[rd_req.ptr] + rd_step;
      end
      // Load of read data; a misaligned read still completes
      if (rd_req.en && rd_req.load) begin
        if (rd_req.byte_op) begin
          wreg_q[rd_req.dest][7:0] <= rd_sel[7:0];
        end else begin
          wreg_q[rd_req.dest] <= rd_sel;
        end
      end
      // Extension operations on the low byte
      case (reg_op.op)
        dsa_pkg::OP_SIGN_EXTEND: begin
          wreg_q[reg_op.sel] <= {{8{wreg_q[reg_op.sel][7]}}, wreg_q[reg_op.sel][7:0]};
        end
        dsa_pkg::OP_CLEAR_UPPER: begin
          wreg_q[reg_op.sel] <= {8'h00, wreg_q[reg_op.sel][7:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_resp_q <= '0;
    end else begin
      rd_resp_q.valid <= rd_req.en;
      rd_resp_q.data  <= rd_req.en ? rd_sel : 16'h0000;
    end
  end

  // Trap pulse after any odd word access
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr_trap_q <= 1'b0;
    end else begin
      addr_trap_q <= rd_mis | wr_mis;
    end
  end

  // Helper views for the checks below
  logic [15:0] wr_old;   // RAM word under the store address
  logic [15:0] rd_ptr_v; // Read pointer value
  logic [15:0] dest_v;   // Load destination value
  logic [15:0] op_v;     // Operated register value
  logic [15:0] dma_word; // RAM word under the DMA address
  assign dma_word = ram_q[dma_idx];
  assign wr_old   = ram_q[wr_idx];
  assign rd_ptr_v = wreg_q[rd_req.ptr];
  assign dest_v   = wreg_q[rd_req.dest];
  assign op_v     = wreg_q[reg_op.sel];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_upper_half_zero:
  assert property (rd_req.en && rd_effective_address[15] |=> rd_resp_q.valid && rd_resp_q.data == 16'h0000)
    else $error("reserved half read not zero");

  chk_beyond_ram_zero:
  assert property (rd_req.en && !rd_effective_address[15] && rd_effective_address > `DSA_RAM_END
                   |=> rd_resp_q.data == 16'h0000)
    else $error("read beyond RAM not zero");

  chk_unused_reg_zero:
  assert property (rd_req.en && rd_effective_address > `DSA_WREG_END && rd_effective_address < `DSA_RAM_BASE
                   |=> rd_resp_q.data == 16'h0000)
    else $error("unused register address not zero");

  chk_byte_read_lane:
  assert property (rd_req.en && rd_req.byte_op |=> rd_resp_q.data[15:8] == 8'h00 &&
                   rd_resp_q.data[7:0] == ($past(rd_effective_address[0]) ? $past(rd_word[15:8]) :
                                                                           $past(rd_word[7:0])))
    else $error("byte read lane wrong");

  chk_read_answered:
  assert property (rd_req.en |=> rd_resp_q.valid)
    else $error("read request not answered");

  chk_idle_answer_low:
  assert property (!rd_req.en |=> !rd_resp_q.valid && rd_resp_q.data == 16'h0000)
    else $error("answer without read request");

  chk_word_trap:
  assert property ((rd_mis || wr_mis) |=> addr_trap_q ##1 !addr_trap_q || $past(rd_mis || wr_mis))
    else $error("odd word access without trap");

  chk_no_false_trap:
  assert property (!rd_mis && !wr_mis |=> !addr_trap_q)
    else $error("trap without odd word access");

  chk_store_blocked:
  assert property (wr_mis && wr_in_ram && dma_lane == 2'b00 |=> ram_q[$past(wr_idx)] == $past(wr_old))
    else $error("misaligned store changed RAM");

  chk_postinc_step:
  assert property (rd_req.en && rd_req.mode == dsa_pkg::AM_IND_POSTINC && !rd_req.load && !wr_req.en &&
                   reg_op.op == dsa_pkg::OP_NONE |=> wreg_q[$past(rd_req.ptr)] == $past(rd_ptr_v) + $past(rd_step))
    else $error("post-increment step wrong");

  chk_byte_load_low:
  assert property (rd_req.en && rd_req.load && rd_req.byte_op && !wr_req.en && reg_op.op == dsa_pkg::OP_NONE &&
                   rd_req.mode != dsa_pkg::AM_IND_POSTINC
                   |=> wreg_q[$past(rd_req.dest)] == {$past(dest_v[15:8]), $past(rd_sel[7:0])})
    else $error("byte load touched high byte");

  chk_sign_extend:
  assert property (reg_op.op == dsa_pkg::OP_SIGN_EXTEND && !wr_req.en && !rd_req.en
                   |=> wreg_q[$past(reg_op.sel)] == {{8{$past(op_v[7])}}, $past(op_v[7:0])})
    else $error("sign extension wrong");

  chk_clear_upper:
  assert property (reg_op.op == dsa_pkg::OP_CLEAR_UPPER && !wr_req.en && !rd_req.en
                   |=> wreg_q[$past(reg_op.sel)] == {8'h00, $past(op_v[7:0])})
    else $error("clear upper byte wrong");

  chk_dma_read_word:
  assert property (dma_req.en && !dma_req.we |=> dma_rdata_q == $past(dma_word))
    else $error("DMA read data wrong");

  chk_cpu_wins:
  assert property (wr_in_ram && wr_lane == 2'b11 && dma_lane == 2'b11 && wr_idx == dma_idx
                   |=> ram_q[$past(wr_idx)] == $past(wr_req.data))
    else $error("DMA write beat CPU write");

  cov_collision: cover property (wr_in_ram && wr_lane != 2'b00 && dma_lane != 2'b00 && wr_idx == dma_idx);
  cov_misaligned_store: cover property (wr_mis ##1 addr_trap_q);
  // Main scenarios that should each be seen at least once
  cov_byte_load: cover property (rd_req.en && rd_req.load && rd_req.byte_op && rd_effective_address[0]);
  cov_dma_read: cover property (dma_req.en && !dma_req.we);
  cov_clear_upper: cover property (reg_op.op == dsa_pkg::OP_CLEAR_UPPER);

endmodule

`default_nettype wire

//--- tb/dma_ctl_model.sv
`default_nettype none

// Stand-in for the DMA controller on the dual-ported side
module dma_ctl_model (
  input  wire logic              core_clk,
  output var  dsa_pkg::dma_req_t dma_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle until the first transfer
  initial dma_req = '0;

  // One transfer, called just after a rising edge; held until the taking edge
  task automatic xfer(input logic w, input logic [9:0] a, input logic [1:0] be, input logic [15:0] dt);
    dma_req = '{en: 1'b1, we: w, addr: a, be: be, data: dt};
    @(posedge core_clk);
    #2;
    // Released: leftovers inverted so stale values cannot pass by chance
    dma_req = '{en: 1'b0, we: 1'b0, addr: ~a, be: 2'b00, data: ~dt};
    @(posedge core_clk);
    #2;
  endtask

endmodule

`default_nettype wire

//--- tb/tb_data_space_access_unit.sv
`default_nettype none

module tb_data_space_access_unit;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 core_clk;     // 25 MHz core clock
  logic                 nrst;         // Synchronous reset, active low
  dsa_pkg::rd_req_t     rd_req;       // Read port stimulus
  dsa_pkg::wr_req_t     wr_req;       // Write port stimulus
  dsa_pkg::reg_op_req_t reg_op;       // Register operation stimulus
  dsa_pkg::dma_req_t    dma_req;      // Driven by the DMA model
  dsa_pkg::rd_resp_t    rd_resp_q;    // Read answer
  logic                 addr_trap_q;  // Address trap pulse
  logic [15:0]          dma_rdata_q;  // DMA read data
  int                   failures;     // Mismatch count
  int                   n_tests;      // Comparison count
  int                   cycles;       // Hang guard
  logic [15:0]          d;            // Last read data
  logic                 t;            // Last trap sample
  logic                 v;            // Last answer valid sample

  data_space_access_unit u_dut (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .rd_req     (rd_req),
    .wr_req     (wr_req),
    .reg_op     (reg_op),
    .dma_req    (dma_req),
    .rd_resp_q  (rd_resp_q),
    .addr_trap_q(addr_trap_q),
    .dma_rdata_q(dma_rdata_q)
  );

  dma_ctl_model u_dma (
    .core_clk(core_clk),
    .dma_req (dma_req)
  );

  // Clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Whole run needs under a hundred cycles; far above that means a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  // Step to just after the next rising edge
  task automatic cyc;
    @(posedge core_clk);
    #2;
  endtask

  // Value comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One read; answer and trap sampled in the cycle they stand
  task automatic rd(input logic b, input dsa_pkg::addr_mode_t m, input logic [3:0] p, input logic [15:0] a,
                    input logic ld);
    rd_req = '{en: 1'b1, byte_op: b, mode: m, ptr: p, lit: a, load: ld, dest: 4'h3};
    cyc();
    d = rd_resp_q.data;
    t = addr_trap_q;
    v = rd_resp_q.valid;
    rd_req.en = 1'b0;
    cyc();
  endtask

  // One write; trap sampled the cycle after the taking edge
  task automatic wr(input logic b, input dsa_pkg::addr_mode_t m, input logic [3:0] p, input logic [15:0] a,
                    input logic [15:0] dt);
    wr_req = '{en: 1'b1, byte_op: b, mode: m, ptr: p, lit: a, data: dt};
    cyc();
    t = addr_trap_q;
    wr_req.en = 1'b0;
    cyc();
  endtask

  // One register operation on W3, then read it back
  task automatic op3(input dsa_pkg::reg_op_t o);
    reg_op = '{op: o, sel: 4'h3};
    cyc();
    reg_op.op = dsa_pkg::OP_NONE;
    cyc();
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0006, 1'b0);
  endtask

  // Byte lanes of one RAM word
  task automatic t_lanes;
    wr(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0800, 16'h1280);
    rd(1'b1, dsa_pkg::AM_DIRECT, 4'h0, 16'h0800, 1'b0);
    chk(d, 16'h0080);
    wr(1'b1, dsa_pkg::AM_DIRECT, 4'h0, 16'h0801, 16'h0077);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0800, 1'b0);
    chk(d, 16'h7780);
    rd(1'b1, dsa_pkg::AM_DIRECT, 4'h0, 16'h0801, 1'b0);
    chk(d, 16'h0077);
    $display("test lanes done");
  endtask

  // Odd word accesses
  task automatic t_misalign;
    wr(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0801, 16'hFFFF);
    chk({15'h0, t}, 16'h0001);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0800, 1'b0);
    chk(d, 16'h7780);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0801, 1'b0);
    chk({15'h0, t}, 16'h0001);
    chk({15'h0, v}, 16'h0001);
    chk(d, 16'h7780);
    $display("test misalign done");
  endtask

  // Pointer steps, W2 lives at 0x0004
  task automatic t_postinc;
    wr(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0004, 16'h0800);
    rd(1'b1, dsa_pkg::AM_IND_POSTINC, 4'h2, 16'h0000, 1'b0);
    chk(d, 16'h0080);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0004, 1'b0);
    chk(d, 16'h0801);
    rd(1'b0, dsa_pkg::AM_IND_POSTINC, 4'h2, 16'h0000, 1'b0);
    chk({15'h0, t}, 16'h0001);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0004, 1'b0);
    chk(d, 16'h0803);
    wr(1'b1, dsa_pkg::AM_IND_POSTINC, 4'h2, 16'h0000, 16'h0055);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0004, 1'b0);
    chk(d, 16'h0804);
    $display("test postinc done");
  endtask

  // Byte load and register operations on W3 at 0x0006
  task automatic t_regops;
    wr(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0006, 16'hABCD);
    rd(1'b1, dsa_pkg::AM_DIRECT, 4'h0, 16'h0800, 1'b1);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0006, 1'b0);
    chk(d, 16'hAB80);
    op3(dsa_pkg::OP_SIGN_EXTEND);
    chk(d, 16'hFF80);
    op3(dsa_pkg::OP_CLEAR_UPPER);
    chk(d, 16'h0080);
    $display("test regops done");
  endtask

  // Address decode corners
  task automatic t_map;
    rd(1'b0, dsa_pkg::AM_NEAR, 4'h0, 16'hE800, 1'b0);
    chk(d, 16'h7780);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h8000, 1'b0);
    chk(d, 16'h0000);
    rd(1'b1, dsa_pkg::AM_DIRECT, 4'h0, 16'h0101, 1'b0);
    chk(d, 16'h0000);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h2000, 1'b0);
    chk(d, 16'h0000);
    $display("test map done");
  endtask

  // Mid-run reset with an odd word read pending; outputs and W2 must clear
  task automatic t_reset;
    rd_req = '{en: 1'b1, byte_op: 1'b0, mode: dsa_pkg::AM_DIRECT, ptr: 4'h0, lit: 16'h0801, load: 1'b0,
               dest: 4'h3};
    nrst   = 1'b0;
    cyc();
    chk({14'h0, rd_resp_q.valid, addr_trap_q}, 16'h0000);
    chk(dma_rdata_q, 16'h0000);
    rd_req.en = 1'b0;
    nrst      = 1'b1;
    cyc();
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h0004, 1'b0);
    chk(d, 16'h0000);
    $display("test reset done");
  endtask

  // Shared DMA area and write collision
  task automatic t_dma;
    wr(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h1806, 16'hFFFF);
    u_dma.xfer(1'b1, 10'h003, 2'b01, 16'h1234);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h1806, 1'b0);
    chk(d, 16'hFF34);
    fork
      wr(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h1804, 16'hA5A5);
      u_dma.xfer(1'b1, 10'h002, 2'b11, 16'h5A5A);
    join
    u_dma.xfer(1'b0, 10'h002, 2'b00, 16'h0000);
    chk(dma_rdata_q, 16'hA5A5);
    rd(1'b0, dsa_pkg::AM_DIRECT, 4'h0, 16'h1804, 1'b0);
    chk(d, 16'hA5A5);
    $display("test dma done");
  endtask

  // Counts, verdict, end of run
  task automatic complete_run;
    $display("counts: tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    failures = 0;
    n_tests  = 0;
    cycles   = 0;
    nrst     = 1'b0;
    rd_req   = '0;
    wr_req   = '0;
    reg_op   = '0;
    repeat (8) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    // First request only after an edge has seen reset released
    cyc();
    t_lanes();
    t_misalign();
    t_postinc();
    t_regops();
    t_map();
    t_dma();
    t_reset();
    complete_run();
  end

endmodule

`default_nettype wire
